// ---- verilog/pvs_pkg.sv ----
// Package for the vendor status register bank: command codes, bit
// positions, reset values and thresholds.
// Assumes the serial management engine decodes frames into commands.
package pvs_pkg;

  // Command codes seen on the decoded command port
  localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CMD_NVM_CORR      = 8'hB6;
  localparam logic [7:0] CMD_PIN_STATE     = 8'hE5;
  localparam logic [7:0] CMD_SHARED_COND   = 8'hEF;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;

  // Answer lengths in bytes
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h2;

  // Vendor fault status bit positions
  localparam int VS_OT_FAULT   = 7;
  localparam int VS_OT_WARN    = 6;
  localparam int VS_CRC_ERR    = 5;
  localparam int VS_PLL_UNLOCK = 4;
  localparam int VS_FAULT_LOG  = 3;
  localparam int VS_SHORT_CYC  = 1;
  localparam int VS_FPIN_LOW   = 0;
  localparam logic [7:0] VS_SUPPORTED = 8'hFB;  // Bit 2 never set
  localparam logic [7:0] VS_RESET     = 8'h00;

  // Pin-state word field positions
  localparam int PS_SLAVE     = 14;  // Bits 15:14, channel 1 high
  localparam int PS_IOUT_BAD  = 11;
  localparam int PS_SYNC_DIS  = 10;
  localparam int PS_PGOOD     = 8;   // Bits 9:8
  localparam int PS_RUN_PULL  = 6;   // Bits 7:6
  localparam int PS_RUN_LVL   = 4;   // Bits 5:4
  localparam int PS_FPIN_PULL = 2;   // Bits 3:2
  localparam int PS_FPIN_LVL  = 0;   // Bits 1:0

  // Shared condition byte bit positions
  localparam int SC_NO_ALERT   = 7;
  localparam int SC_NOT_BUSY   = 6;
  localparam int SC_NO_CALC    = 5;
  localparam int SC_NO_TRANS   = 4;
  localparam int SC_NVM_INIT   = 3;
  localparam int SC_TB_TIMEOUT = 1;
  localparam int SC_WP_LVL     = 0;

  // Correction word: bit 5 is one when no corrections were made
  localparam int  NC_NO_CORR    = 5;
  localparam logic NC_RESET_BIT = 1'b1;

  // Summary fault word position of the vendor summary flag
  localparam int SUMMARY_VENDOR_BIT = 12;

  // Internal temperature thresholds in degrees C
  localparam logic [9:0] TEMP_FAULT_C = 10'd160;
  localparam logic [9:0] TEMP_WARN_C  = 10'd130;

endpackage

// ---- verilog/pvs_sync.sv ----
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the pins are quasi-static with respect to mclk.
`timescale 1ns/10ps
module pvs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pvs_sync

// ---- verilog/pvs_status_bank.sv ----
// Vendor status and pin-state register bank of a dual-channel power
// controller, with the fault-clear command and fault latch-off.
// Assumes a same-clock serial engine hands over decoded commands.
//
// What this block does
// - Bits 7/6 set above 160C / 130C
// - Bits 5,4,3,1,0 report conditions; bit 2 zero
// - Any vendor bit sets summary flag, alert
// - Writing one clears that vendor bit only
// - Pin word: slaves, current suspect, sync off
// - Pin word bits 9:8 report power good, forced high for slaves
// - Pin word bits 7:0 show run/fault pins
// - Pin and correction words read-only, two bytes
// - Shared byte 7:4 alert, busy, calc, transition
// - Shared byte 3,1,0 nvm, timebase, protect pin
// - Correction bit 5 low if corrections made
// - Correction bit updated on reload, reset, bulk
// - Fault-clear clears all bits, releases alert
// - Fault-clear never restarts latched-off channel
// - Latched channel restarts after off then on
// - Persistent fault resets bit, alert again
// - Summary flag sits at summary bit 12
`timescale 1ns/10ps
module pvs_status_bank #(
  parameter int NCH = 2
) (
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire logic           ce,
  // Decoded command port from the serial engine
  input  wire logic           cmd_stb,
  input  wire logic [7:0]     cmd_code,
  input  wire logic           cmd_wr,
  input  wire logic [1:0]     cmd_nbytes,
  input  wire logic [7:0]     cmd_wdata,
  output logic                rsp_valid,
  output logic [15:0]         rsp_data,
  output logic [1:0]          rsp_nbytes,
  output logic                rsp_err,
  // Internal conditions, same clock
  input  wire logic [9:0]     temp_c,
  input  wire logic           nvm_crc_err,
  input  wire logic           pll_unlocked,
  input  wire logic           fault_log_present,
  input  wire logic           short_cycled,
  input  wire logic [NCH-1:0] chan_slave,
  input  wire logic           iout_adc_suspect,
  input  wire logic [NCH-1:0] chan_pgood,
  input  wire logic [NCH-1:0] fault_pin_pull,
  input  wire logic           busy,
  input  wire logic           calc_pending,
  input  wire logic           out_in_transition,
  input  wire logic           nvm_initialized,
  input  wire logic           timebase_timeout,
  input  wire logic           nvm_ecc_corrected,
  input  wire logic           nvm_reload_done,
  input  wire logic           reset_cmd_done,
  input  wire logic           nvm_bulk_read_done,
  input  wire logic [NCH-1:0] chan_fault_trip,
  input  wire logic [NCH-1:0] onoff_cmd,
  // Pins, asynchronous to mclk
  input  wire logic [NCH-1:0] run_pin_i,
  output logic      [NCH-1:0] run_pin_o,
  output logic      [NCH-1:0] run_pin_oe,
  input  wire logic [NCH-1:0] fault_pin_i,
  output logic      [NCH-1:0] fault_pin_o,
  output logic      [NCH-1:0] fault_pin_oe,
  input  wire logic           wp_pin_i,
  input  wire logic           sync_dis_pin_i,
  output logic                alert_o,
  output logic                alert_oe,
  // Results
  output logic                vendor_summary_flag,
  output logic [15:0]         summary_vendor_mask,
  output logic [NCH-1:0]      chan_enable,
  output logic [NCH-1:0]      chan_latched_off
);

  // Synchronised pin levels
  logic [NCH-1:0] run_lvl;
  logic [NCH-1:0] fpin_lvl;
  logic           wp_lvl;
  logic           sync_dis_lvl;

  logic [7:0]     vstat_r;
  logic [7:0]     vstat_nxt;
  logic [7:0]     vset;
  logic [7:0]     vclr;
  logic           alert_r;
  logic           alert_nxt;
  logic           no_corr_r;
  logic           por_seen_r;
  logic [NCH-1:0] latch_r;
  logic [NCH-1:0] want_on;
  logic [15:0]    pin_word;
  logic [7:0]     shared_byte;
  logic [15:0]    corr_word;
  logic           clear_cmd;
  logic           vs_write;

  // Responder states
  typedef enum logic [1:0] {
    PVS_IDLE = 2'b01,
    PVS_ANS  = 2'b10
  } pvs_state_t;
  pvs_state_t state_r;
  pvs_state_t state_nxt;

  // A command code the bank can answer on a read
  function automatic logic known_read(input logic [7:0] code);
    known_read = (code == pvs_pkg::CMD_VENDOR_STATUS) ||
                 (code == pvs_pkg::CMD_PIN_STATE) ||
                 (code == pvs_pkg::CMD_SHARED_COND) ||
                 (code == pvs_pkg::CMD_NVM_CORR);
  endfunction

  // Answer length of a readable command
  function automatic logic [1:0] read_len(input logic [7:0] code);
    case (code)
      pvs_pkg::CMD_VENDOR_STATUS: read_len = pvs_pkg::LEN_BYTE;
      pvs_pkg::CMD_SHARED_COND:   read_len = pvs_pkg::LEN_BYTE;
      pvs_pkg::CMD_PIN_STATE:     read_len = pvs_pkg::LEN_WORD;
      pvs_pkg::CMD_NVM_CORR:      read_len = pvs_pkg::LEN_WORD;
      default:                    read_len = pvs_pkg::LEN_NONE;
    endcase
  endfunction

  // Pin synchronisers
  pvs_sync #(.WIDTH(2*NCH+2)) u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .async_in ({run_pin_i, fault_pin_i, wp_pin_i, sync_dis_pin_i}),
    .sync_out ({run_lvl, fpin_lvl, wp_lvl, sync_dis_lvl})
  );

  // Command decode: fault-clear is a write with no data
  assign clear_cmd = cmd_stb && cmd_wr &&
                     (cmd_code == pvs_pkg::CMD_CLEAR_FAULTS) &&
                     (cmd_nbytes == pvs_pkg::LEN_NONE);
  assign vs_write  = cmd_stb && cmd_wr &&
                     (cmd_code == pvs_pkg::CMD_VENDOR_STATUS) &&
                     (cmd_nbytes == pvs_pkg::LEN_BYTE);

  // Conditions that set vendor status bits each cycle they hold
  always_comb begin
    vset = 8'h00;
    vset[pvs_pkg::VS_OT_FAULT]   = temp_c > pvs_pkg::TEMP_FAULT_C;
    vset[pvs_pkg::VS_OT_WARN]    = temp_c > pvs_pkg::TEMP_WARN_C;
    vset[pvs_pkg::VS_CRC_ERR]    = nvm_crc_err;
    vset[pvs_pkg::VS_PLL_UNLOCK] = pll_unlocked;
    vset[pvs_pkg::VS_FAULT_LOG]  = fault_log_present;
    vset[pvs_pkg::VS_SHORT_CYC]  = short_cycled;
    vset[pvs_pkg::VS_FPIN_LOW]   = ~&fpin_lvl;
    vset = vset & pvs_pkg::VS_SUPPORTED;
  end

  // Clear mask: fault-clear wipes all, a write clears its ones
  always_comb begin
    vclr = 8'h00;
    if (clear_cmd) begin
      vclr = 8'hFF;
    end else if (vs_write) begin
      vclr = cmd_wdata & pvs_pkg::VS_SUPPORTED;
    end
  end

  // Set wins over clear, so a lasting condition stays visible
  assign vstat_nxt = (vstat_r & ~vclr) | vset;

  // Vendor fault status register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vstat_r <= pvs_pkg::VS_RESET;
    end else if (ce) begin
      vstat_r <= vstat_nxt;
    end
  end

  // Alert raised on a newly set bit; dropped only by fault-clear
  always_comb begin
    alert_nxt = alert_r | (|(vset & ~vstat_r));
    if (clear_cmd) begin
      alert_nxt = |vset;
    end
  end

  // Alert line drive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      alert_r <= 1'b0;
    end else if (ce) begin
      alert_r <= alert_nxt;
    end
  end

  assign alert_o  = 1'b0;
  assign alert_oe = alert_r;

  // Summary flag follows any set vendor bit
  assign vendor_summary_flag = |vstat_r;
  assign summary_vendor_mask =
    16'(vendor_summary_flag) << pvs_pkg::SUMMARY_VENDOR_BIT;

  // Catch the first cycle after power-on reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      por_seen_r <= 1'b0;
    end else if (ce) begin
      por_seen_r <= 1'b1;
    end
  end

  // Correction status: updated only on its four events
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      no_corr_r <= pvs_pkg::NC_RESET_BIT;
    end else if (ce) begin
      if (!por_seen_r || nvm_reload_done || reset_cmd_done ||
          nvm_bulk_read_done) begin
        no_corr_r <= ~nvm_ecc_corrected;
      end
    end
  end

  // A channel asks to run when both on-off command and run pin agree
  assign want_on = onoff_cmd & run_lvl;

  // Fault latch-off: only an off request releases it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (chan_fault_trip[i]) begin
          latch_r[i] <= 1'b1;
        end else if (!want_on[i]) begin
          latch_r[i] <= 1'b0;
        end
      end
    end
  end

  // Fault-clear has no path into the latch above
  assign chan_latched_off = latch_r;
  assign chan_enable      = want_on & ~latch_r;

  // Latched channels hold their run pin low
  assign run_pin_o    = '0;
  assign run_pin_oe   = latch_r;
  assign fault_pin_o  = '0;
  assign fault_pin_oe = fault_pin_pull;

  // Pin-state word assembly
  always_comb begin
    pin_word = 16'h0000;
    pin_word[pvs_pkg::PS_SLAVE +: NCH]     = chan_slave;
    pin_word[pvs_pkg::PS_IOUT_BAD]         = iout_adc_suspect;
    pin_word[pvs_pkg::PS_SYNC_DIS]         = sync_dis_lvl;
    pin_word[pvs_pkg::PS_PGOOD +: NCH]     = chan_pgood | chan_slave;
    pin_word[pvs_pkg::PS_RUN_PULL +: NCH]  = run_pin_oe;
    pin_word[pvs_pkg::PS_RUN_LVL +: NCH]   = run_lvl;
    pin_word[pvs_pkg::PS_FPIN_PULL +: NCH] = fault_pin_oe;
    pin_word[pvs_pkg::PS_FPIN_LVL +: NCH]  = fpin_lvl;
  end

  // Shared condition byte assembly
  always_comb begin
    shared_byte = 8'h00;
    shared_byte[pvs_pkg::SC_NO_ALERT]   = ~alert_r;
    shared_byte[pvs_pkg::SC_NOT_BUSY]   = ~busy;
    shared_byte[pvs_pkg::SC_NO_CALC]    = ~calc_pending;
    shared_byte[pvs_pkg::SC_NO_TRANS]   = ~out_in_transition;
    shared_byte[pvs_pkg::SC_NVM_INIT]   = nvm_initialized;
    shared_byte[pvs_pkg::SC_TB_TIMEOUT] = timebase_timeout;
    shared_byte[pvs_pkg::SC_WP_LVL]     = wp_lvl;
  end

  // Correction word: reserved bits read zero
  always_comb begin
    corr_word = 16'h0000;
    corr_word[pvs_pkg::NC_NO_CORR] = no_corr_r;
  end

  // Responder: answer one cycle after a read strobe
  always_comb begin
    case (state_r)
      PVS_IDLE: state_nxt = (cmd_stb && !cmd_wr) ? PVS_ANS : PVS_IDLE;
      PVS_ANS:  state_nxt = (cmd_stb && !cmd_wr) ? PVS_ANS : PVS_IDLE;
      default:  state_nxt = PVS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= PVS_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Read data and answer flags from flip-flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid  <= 1'b0;
      rsp_data   <= 16'h0000;
      rsp_nbytes <= pvs_pkg::LEN_NONE;
      rsp_err    <= 1'b0;
    end else if (ce) begin
      rsp_valid  <= 1'b0;
      rsp_err    <= 1'b0;
      if (cmd_stb && !cmd_wr) begin
        rsp_valid  <= 1'b1;
        rsp_nbytes <= read_len(cmd_code);
        rsp_err    <= !known_read(cmd_code);
        case (cmd_code)
          pvs_pkg::CMD_VENDOR_STATUS: rsp_data <= {8'h00, vstat_r};
          pvs_pkg::CMD_PIN_STATE:     rsp_data <= pin_word;
          pvs_pkg::CMD_SHARED_COND:   rsp_data <= {8'h00, shared_byte};
          pvs_pkg::CMD_NVM_CORR:      rsp_data <= corr_word;
          default:                    rsp_data <= 16'h0000;
        endcase
      end else if (cmd_stb && cmd_wr) begin
        // Writes to read-only or unknown codes store nothing
        rsp_err <= !(clear_cmd || vs_write);
      end
    end
  end

endmodule // pvs_status_bank

// ---- test/pvs_status_bank_properties.sv ----
// Checker for the vendor status bank, watching only the top-level ports.
// Assumes one clock domain and ce held high whenever commands are sent.
`timescale 1ns/10ps
module pvs_status_bank_chk #(
  parameter int NCH = 2
) (
  input wire logic           mclk,
  input wire logic           rstn,
  input wire logic           ce,
  input wire logic           cmd_stb,
  input wire logic [7:0]     cmd_code,
  input wire logic           cmd_wr,
  input wire logic [9:0]     temp_c,
  input wire logic [NCH-1:0] chan_fault_trip,
  input wire logic           rsp_valid,
  input wire logic [15:0]    rsp_data,
  input wire logic [1:0]     rsp_nbytes,
  input wire logic           rsp_err,
  input wire logic           alert_oe,
  input wire logic           vendor_summary_flag,
  input wire logic [15:0]    summary_vendor_mask,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic [NCH-1:0] chan_latched_off,
  input wire logic [NCH-1:0] run_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Read strobe taken this cycle
  logic rd;
  assign rd = ce && cmd_stb && !cmd_wr;

  AST_TEMP_FAULT: assert property (ce && temp_c > 10'h0A0 |=>
    vendor_summary_flag) else $error("hot die did not flag");
  AST_VS_BIT2: assert property (rd && cmd_code == 8'h80 |=>
    rsp_data[2] == 1'b0 && rsp_nbytes == 2'h1) else $error("vs bit2");
  AST_ALERT_CAUSE: assert property ($rose(alert_oe) |->
    vendor_summary_flag) else $error("alert without vendor bit");
  AST_PIN_RSV: assert property (rd && cmd_code == 8'hE5 |=>
    rsp_data[13:12] == 2'h0) else $error("pin word 13:12 set");
  AST_WORD_READ: assert property (
    rd && cmd_code inside {8'hE5, 8'hB6}
    |=> rsp_valid && !rsp_err && rsp_nbytes == 2'h2) else $error("word len");
  AST_SHARED_READ: assert property (rd && cmd_code == 8'hEF |=>
    rsp_nbytes == 2'h1 && rsp_data[2] == 1'b0) else $error("shared byte");
  AST_NO_RESTART: assert property (
    (chan_enable & chan_latched_off) == '0)
    else $error("latched channel enabled");
  AST_TRIP_LATCH: assert property (ce && chan_fault_trip[0] |=>
    chan_latched_off[0] [*2] or !rstn) else $error("trip not latched");
  AST_RUN_PULL: assert property (run_pin_oe == chan_latched_off)
    else $error("run pull mismatch");
  AST_MASK_BIT12: assert property (summary_vendor_mask ==
    {3'h0, vendor_summary_flag, 12'h000}) else $error("summary mask");
  AST_RO_WRITE: assert property (ce && cmd_stb && cmd_wr &&
    cmd_code inside {8'hE5, 8'hEF, 8'hB6} |=> rsp_err && !rsp_valid)
    else $error("read-only write accepted");
endmodule // pvs_status_bank_chk

bind pvs_status_bank pvs_status_bank_chk #(.NCH(NCH)) u_chk (.*);

// ---- test/pvs_host.sv ----
// Host-side model issuing decoded commands to the status bank.
// Assumes the answer lands one cycle after the strobe is taken.
`timescale 1ns/10ps
module pvs_host (
  input  wire logic        mclk,
  output logic             cmd_stb,
  output logic [7:0]       cmd_code,
  output logic             cmd_wr,
  output logic [1:0]       cmd_nbytes,
  output logic [7:0]       cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_err
);
  logic [15:0] rd_data;
  logic        rd_err;
  logic        rd_valid;
  // Idle bus at time zero
  initial begin
    cmd_stb = 1'b0;
    cmd_code = 8'hFF;
    cmd_wr = 1'b0;
    cmd_nbytes = 2'h0;
    cmd_wdata = 8'h00;
  end
  // One command; the answer is captured at the edge after the taking edge
  task automatic issue(input logic [7:0] c, input logic w,
                       input logic [1:0] n, input logic [7:0] d);
    @(posedge mclk);
    cmd_stb <= 1'b1;
    cmd_code <= c;
    cmd_wr <= w;
    cmd_nbytes <= n;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_stb <= 1'b0;
    cmd_wdata <= ~d;  // Stale byte never repeats the last value
    // The answer launched at the taking edge stands until this edge
    @(posedge mclk);
    rd_data = rsp_data;
    rd_err = rsp_err;
    rd_valid = rsp_valid;
  endtask
endmodule // pvs_host

// ---- test/pvs_status_bank_tb.sv ----
// Self-checking bench for the vendor status bank.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/10ps
module pvs_status_bank_tb;
  logic mclk, rstn, ce, cmd_stb, cmd_wr, rsp_valid, rsp_err;
  logic [7:0] cmd_code, cmd_wdata;
  logic [1:0] cmd_nbytes, rsp_nbytes, chan_slave, chan_pgood;
  logic [15:0] rsp_data, summary_vendor_mask;
  logic [9:0] temp_c;
  logic nvm_crc_err, pll_unlocked, fault_log_present, short_cycled;
  logic iout_adc_suspect, busy, calc_pending, out_in_transition;
  logic nvm_initialized, timebase_timeout, nvm_ecc_corrected;
  logic nvm_reload_done, reset_cmd_done, nvm_bulk_read_done;
  logic wp_pin_i, sync_dis_pin_i, alert_oe, vendor_summary_flag;
  logic [1:0] fault_pin_pull, chan_fault_trip, onoff_cmd, run_pin_i;
  logic [1:0] run_pin_oe, fault_pin_i, fault_pin_oe, chan_enable;
  logic [1:0] chan_latched_off;
  int n_errors, compares, cycles;

  pvs_status_bank #(.NCH(2)) u_dut (.mclk, .rstn, .ce, .cmd_stb,
    .cmd_code, .cmd_wr, .cmd_nbytes, .cmd_wdata, .rsp_valid, .rsp_data,
    .rsp_nbytes, .rsp_err, .temp_c, .nvm_crc_err, .pll_unlocked,
    .fault_log_present, .short_cycled, .chan_slave, .iout_adc_suspect,
    .chan_pgood, .fault_pin_pull, .busy, .calc_pending, .out_in_transition,
    .nvm_initialized, .timebase_timeout, .nvm_ecc_corrected,
    .nvm_reload_done, .reset_cmd_done, .nvm_bulk_read_done,
    .chan_fault_trip, .onoff_cmd, .run_pin_i, .run_pin_o(), .run_pin_oe,
    .fault_pin_i, .fault_pin_o(), .fault_pin_oe, .wp_pin_i, .sync_dis_pin_i,
    .alert_o(), .alert_oe, .vendor_summary_flag, .summary_vendor_mask,
    .chan_enable, .chan_latched_off);
  pvs_host u_host (.mclk, .cmd_stb, .cmd_code, .cmd_wr, .cmd_nbytes,
    .cmd_wdata, .rsp_valid, .rsp_data, .rsp_err);

  // Clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rdm(input logic [7:0] c, input logic [15:0] m,
                     input logic [15:0] e);
    u_host.issue(c, 1'b0, 2'h0, 8'h00);
    check_val(u_host.rd_data & m, e);
  endtask
  task automatic clr();
    u_host.issue(8'h03, 1'b1, 2'h0, 8'h00);  // No data bytes
    cyc(1);
  endtask
  // Drives one vendor condition on or off by table index
  task automatic set_cond(input int i, input logic on);
    temp_c <= !on ? 10'h019 : i == 0 ? 10'h0A1 : i == 1 ? 10'h0A0
            : i == 7 ? 10'h082 : 10'h019;
    nvm_crc_err <= on && i == 2;
    pll_unlocked <= on && i == 3;
    fault_log_present <= on && i == 4;
    short_cycled <= on && i == 5;
    fault_pin_i <= (on && i == 6) ? 2'b00 : 2'b11;
  endtask

  // Each condition sets its bit, one-writes clear it
  task automatic t_vendor();
    logic [7:0] ex [8] = '{8'hC0, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02,
                           8'h01, 8'h00};
    for (int i = 0; i < 8; i++) begin
      set_cond(i, 1'b1);
      cyc(4);
      rdm(8'h80, 16'hFFFF, {8'h00, ex[i]});
      check_val(16'(vendor_summary_flag), 16'(ex[i] != 0));
      check_val(summary_vendor_mask, 16'(ex[i] != 0) << 12);
      set_cond(i, 1'b0);
      cyc(4);
      u_host.issue(8'h80, 1'b1, 2'h1, ex[i]);
      rdm(8'h80, 16'hFFFF, 16'h0000);
      // A one-write clear leaves the alert up until fault-clear
      check_val(16'(alert_oe), 16'(ex[i] != 0));
      clr();
      check_val({15'h0, alert_oe}, 16'h0000);
    end
  endtask
  // Selective clear, zero write, persistent fault across clear
  task automatic t_clear();
    set_cond(2, 1'b1);
    pll_unlocked <= 1'b1;
    cyc(3);
    set_cond(2, 1'b0);
    u_host.issue(8'h80, 1'b1, 2'h1, 8'h10);
    rdm(8'h80, 16'hFFFF, 16'h0020);
    u_host.issue(8'h80, 1'b1, 2'h1, 8'h00);
    rdm(8'h80, 16'hFFFF, 16'h0020);
    fault_log_present <= 1'b1;
    clr();
    rdm(8'h80, 16'hFFFF, 16'h0008);
    check_val({15'h0, alert_oe}, 16'h0001);
    set_cond(0, 1'b0);
    cyc(1);
    clr();
    rdm(8'hEF, 16'h0080, 16'h0080);
  endtask
  // Shared byte levels, then pin word and refusals
  task automatic t_levels();
    rdm(8'hEF, 16'hFFFF, 16'h00DA);
    {busy, calc_pending, out_in_transition} <= 3'b101;
    {nvm_initialized, timebase_timeout, wp_pin_i} <= 3'b001;
    cyc(4);
    rdm(8'hEF, 16'hFFFF, 16'h00A1);
    {chan_slave, iout_adc_suspect, sync_dis_pin_i} <= 4'b1011;
    {chan_pgood, fault_pin_pull, run_pin_i} <= 6'b010101;
    fault_pin_i <= 2'b10;
    cyc(4);
    rdm(8'hE5, 16'hFFFF, 16'h8F16);
    check_val({14'h0, fault_pin_oe}, 16'h0001);
    u_host.issue(8'hE5, 1'b1, 2'h1, 8'hFF);
    check_val({15'h0, u_host.rd_err}, 16'h0001);
    rdm(8'hE5, 16'hFFFF, 16'h8F16);
    u_host.issue(8'h55, 1'b0, 2'h0, 8'h00);
    check_val({u_host.rd_err, u_host.rd_data[14:0]}, 16'h8000);
    {chan_slave, fault_pin_pull, run_pin_i, fault_pin_i} <= 8'h0F;
    // Low fault pin above set vendor bit 0; let the pins settle, then clear
    cyc(2);
    clr();
  endtask
  // Correction bit follows only its update events
  task automatic t_nvm();
    rdm(8'hB6, 16'h0020, 16'h0020);
    nvm_ecc_corrected <= 1'b1;
    cyc(2);
    rdm(8'hB6, 16'h0020, 16'h0020);
    nvm_reload_done <= 1'b1;
    cyc(1);
    nvm_reload_done <= 1'b0;
    rdm(8'hB6, 16'hFFFF, 16'h0000);
    nvm_ecc_corrected <= 1'b0;
    reset_cmd_done <= 1'b1;
    cyc(1);
    reset_cmd_done <= 1'b0;
    rdm(8'hB6, 16'h0020, 16'h0020);
    nvm_ecc_corrected <= 1'b1;
    nvm_bulk_read_done <= 1'b1;
    cyc(1);
    nvm_bulk_read_done <= 1'b0;
    rdm(8'hB6, 16'h0020, 16'h0000);
    // Power-on reset with corrections pending loads a zero
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(4);
    rdm(8'hB6, 16'h0020, 16'h0000);
    clr();
  endtask
  // Latch-off survives a clear and needs an off-on cycle
  task automatic t_latch();
    chan_fault_trip <= 2'b01;
    cyc(1);
    chan_fault_trip <= 2'b00;
    clr();
    check_val({14'h0, chan_latched_off}, 16'h0001);
    rdm(8'hE5, 16'h00C0, 16'h0040);
    onoff_cmd <= 2'b10;
    cyc(2);
    onoff_cmd <= 2'b11;
    cyc(2);
    check_val({12'h0, chan_latched_off, chan_enable}, 16'h0003);
  endtask

  initial begin
    {mclk, rstn, ce, cycles, n_errors, compares} = '0;
    {chan_slave, chan_pgood, fault_pin_pull, chan_fault_trip} = '0;
    {iout_adc_suspect, busy, out_in_transition, wp_pin_i} = '0;
    {nvm_ecc_corrected, nvm_reload_done, reset_cmd_done} = '0;
    {nvm_bulk_read_done, sync_dis_pin_i} = '0;
    {calc_pending, nvm_initialized, timebase_timeout} = 3'b111;
    {onoff_cmd, run_pin_i} = 4'hF;
    set_cond(0, 1'b0);
    cyc(2);
    rstn <= 1'b1;
    ce <= 1'b1;
    cyc(4);
    clr();
    t_nvm();
    t_levels();
    t_vendor();
    t_clear();
    t_latch();
    complete_run();
  end
endmodule // pvs_status_bank_tb
